// ===== verification/lvtg_host_test.sv
// self-checking bench for the lvds panel timing host
`timescale 1ns/1ps
module lvtg_host_test;
   import lvtg_pkg::*;
   localparam int unsigned HT = LVTG_H_TOTAL_MIN;
   logic clk = 0;
   logic pclk = 0;
   logic rst_b = 0;
   logic en = 0;
   logic flip = 1;
   logic mode8 = 1;
   logic valid = 0;
   logic [LVTG_PIX_W-1:0] data = '0;
   logic [LVTG_PIX_W-1:0] rgb;
   logic [LVTG_PIX_W-1:0] last;
   logic ready, pwr, light, oe, de, hs, vs, sflip, under, sync_bad;
   int act, tot, lines, row;
   int n_mismatch = 0;
   int checks = 0;
   int tog = 0;

   initial forever #12.5 clk = ~clk;
   // link clock unrelated in phase to the system clock
   initial begin
      #7;
      forever #24 pclk = ~pclk;
   end

   lvtg_host #(.H_TOTAL(HT), .FALL_CYC(20), .SEQ_CYC(20)) dut (
      .SYS_CLK_I(clk), .RST_B_I(rst_b), .PIX_CLK_I(pclk), .ENABLE_I(en),
      .FLIP_I(flip), .MODE8_I(mode8), .PIX_VALID_I(valid),
      .PIX_DATA_I(data), .PIX_READY_O(ready), .PANEL_PWR_O(pwr),
      .BACKLIGHT_O(light), .LINK_OE_O(oe), .PIXEL_VALID_STROBE_O(de),
      .LINE_SYNC_O(hs), .FRAME_SYNC_O(vs), .SCAN_FLIP_O(sflip),
      .RGB_O(rgb), .UNDERRUN_O(under));

   lvtg_panel_model panel (
      .pix_clk_i(pclk), .strobe_i(de), .line_sync_i(hs),
      .frame_sync_i(vs), .flip_i(sflip), .rgb_i(rgb), .act_o(act),
      .tot_o(tot), .lines_o(lines), .row_o(row), .last_o(last),
      .sync_bad_o(sync_bad));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // ready seen at a falling edge holds through the next rising edge
   task automatic feed(input int n);
      logic r;
      for (int i = 0; i < n; i++) begin
         valid = 1'b1;
         data = {3{LVTG_WHITE_8}};
         r = 1'b0;
         for (int k = 0; k < 5000 && !r; k++) begin
            r = ready;
            @(negedge clk);
         end
         if (!r) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, r, 1'b1);
         end
      end
      valid = 1'b0;
   endtask

   task automatic next_line;
      int n;
      logic u;
      n = lines;
      u = under;
      for (int i = 0; i < 4000 && lines == n; i++) begin
         @(negedge clk);
         if (under !== u) tog++;
         u = under;
      end
      chk(lines, n + 1);
   endtask

   task automatic power_up;
      repeat (2) @(negedge clk);
      chk({pwr, light, oe, de, rgb}, 0);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      chk({pwr, light, oe, de}, 0);
      en = 1'b1;
      for (int i = 0; i < 50 && pwr !== 1'b1; i++) @(negedge clk);
      chk(pwr, 1);
      chk(light, 0);
   endtask

   task automatic stream_modes;
      feed(LVTG_H_ACTIVE);
      next_line();
      chk({oe, sflip, light}, 3'b111);
      chk(act, LVTG_H_ACTIVE);
      chk(last, {3{LVTG_WHITE_8}});
      chk(row, LVTG_V_ACTIVE - 1);
      mode8 = 1'b0;
      tog = 0;
      feed(LVTG_H_ACTIVE);
      next_line();
      chk(tog, 0);
      chk(row, LVTG_V_ACTIVE - 2);
      chk(tot, HT);
      chk(act, LVTG_H_ACTIVE);
      chk(last, {3{LVTG_WHITE_6}});
   endtask

   // nothing fed: the line still runs full length, in black
   task automatic starve_and_stop;
      tog = 0;
      next_line();
      chk(tog > 0, 1);
      chk(act, LVTG_H_ACTIVE);
      chk(tot, HT);
      chk(last, {3{LVTG_BLACK}});
      en = 1'b0;
      for (int i = 0; i < 50 && light !== 1'b0; i++) @(negedge clk);
      chk(light, 0);
      next_line();
      chk({pwr, oe}, 2'b11);
      chk(sync_bad, 0);
   endtask

   initial begin
      power_up();
      stream_modes();
      starve_and_stop();
      give_verdict();
   end

   initial begin
      #1_000_000;
      n_mismatch++;
      give_verdict();
   end
endmodule

// ===== verification/lvtg_panel_model.sv
// behavioural panel on the receiving end of the de-only link
`timescale 1ns/1ps
module lvtg_panel_model (
   input wire logic pix_clk_i,
   input wire logic strobe_i,
   input wire logic line_sync_i,
   input wire logic frame_sync_i,
   input wire logic flip_i,
   input wire logic [lvtg_pkg::LVTG_PIX_W-1:0] rgb_i,
   output int act_o,
   output int tot_o,
   output int lines_o,
   output int row_o,
   output logic [lvtg_pkg::LVTG_PIX_W-1:0] last_o,
   output logic sync_bad_o
);
   import lvtg_pkg::*;
   int act_r;
   int len_r;
   int gap_r;
   logic de_r;
   initial begin
      {act_o, tot_o, lines_o, row_o, act_r, len_r} = '0;
      gap_r = 1000000;
      de_r = 1'b0;
      sync_bad_o = 1'b0;
   end
   // strobe alone times lines; long gap restarts frame
   always @(posedge pix_clk_i) begin
      de_r <= strobe_i;
      len_r <= (strobe_i && !de_r) ? 1 : len_r + 1;
      if (strobe_i) begin
         act_r <= de_r ? act_r + 1 : 1;
         last_o <= rgb_i;
      end else begin
         gap_r <= de_r ? 1 : gap_r + 1;
      end
      if (strobe_i && !de_r) begin
         tot_o <= len_r;
         // rows count down with flip strap high
         if (gap_r > 2 * LVTG_H_TOTAL_MAX) begin
            row_o <= flip_i ? LVTG_V_ACTIVE - 1 : 0;
         end else begin
            row_o <= flip_i ? row_o - 1 : row_o + 1;
         end
      end
      if (!strobe_i && de_r) begin
         act_o <= act_r;
         lines_o <= lines_o + 1;
      end
      // sync pins are ignored, only watched for misuse
      if (line_sync_i || frame_sync_i) begin
         sync_bad_o <= 1'b1;
      end
   end
endmodule

// ===== verilog/lvtg_fifo.sv
// dual clock pixel fifo with gray pointers
`timescale 1ns/1ps
module lvtg_fifo #(
   parameter int W = 25,
   parameter int DEPTH = 16
) (
   input wire logic wclk_i,
   input wire logic wrst_b_i,
   input wire logic w_valid_i,
   output logic w_ready_o,
   input wire logic [W-1:0] w_data_i,
   input wire logic rclk_i,
   input wire logic rrst_b_i,
   lvtg_fifo_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 4 || (1 << AW) != DEPTH) $error("depth not power of two");
   end
   logic [W-1:0] mem_r [DEPTH];
   logic [AW:0] wb_r, wg_r, rb_r, rg_r, wg_s1_r, wg_s2_r, rg_s1_r, rg_s2_r;
   logic [W-1:0] q_r;
   logic q_v_r;
   function automatic logic [AW:0] b2g(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction
   wire full = (wg_r == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
   wire empty = (rg_r == wg_s2_r);
   wire pop = !empty && (!q_v_r || rd.ready);
   // full one write ahead: the caller registers ready, so two free slots
   // are demanded before ready is offered, at the cost of one word of depth
   wire full_nx = (b2g(wb_r + 1'b1) == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
   assign w_ready_o = !full && !full_nx;
   always_ff @(posedge wclk_i) begin
      if (w_valid_i && !full) mem_r[wb_r[AW-1:0]] <= w_data_i;
   end
   always_ff @(posedge wclk_i or negedge wrst_b_i) begin
      if (!wrst_b_i) begin
         wb_r <= '0;
         wg_r <= '0;
         rg_s1_r <= '0;
         rg_s2_r <= '0;
      end else begin
         rg_s1_r <= rg_r;
         rg_s2_r <= rg_s1_r;
         if (w_valid_i && !full) begin
            wb_r <= wb_r + 1'b1;
            wg_r <= b2g(wb_r + 1'b1);
         end
      end
   end
   always_ff @(posedge rclk_i or negedge rrst_b_i) begin
      if (!rrst_b_i) begin
         rb_r <= '0;
         rg_r <= '0;
         wg_s1_r <= '0;
         wg_s2_r <= '0;
         q_v_r <= 1'b0;
         q_r <= '0;
      end else begin
         wg_s1_r <= wg_r;
         wg_s2_r <= wg_s1_r;
         if (pop) begin
            q_r <= mem_r[rb_r[AW-1:0]];
            q_v_r <= 1'b1;
            rb_r <= rb_r + 1'b1;
            rg_r <= b2g(rb_r + 1'b1);
         end else if (rd.ready) begin
            q_v_r <= 1'b0;
         end
      end
   end
   assign rd.valid = q_v_r;
   assign rd.data = q_r;
endmodule

// ===== verilog/lvtg_fifo_if.sv
// valid/ready carrier between the pixel fifo and the link logic
`timescale 1ns/1ps
interface lvtg_fifo_if #(parameter int W = 25);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ===== verilog/lvtg_host.sv
// host timing generator driving a data-enable-only lvds panel
`timescale 1ns/1ps
module lvtg_host
   import lvtg_pkg::*;
#(
   parameter int unsigned H_TOTAL = lvtg_pkg::LVTG_H_TOTAL_TYP,
   parameter int unsigned V_TOTAL = lvtg_pkg::LVTG_V_TOTAL_TYP,
   parameter int unsigned DEPTH = 16,
   parameter longint unsigned FALL_CYC = lvtg_pkg::LVTG_FALL_CYC,
   parameter longint unsigned SEQ_CYC = lvtg_pkg::LVTG_SEQ_CYC
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   input wire logic PIX_CLK_I,
   input wire logic ENABLE_I,
   input wire logic FLIP_I,
   input wire logic MODE8_I,
   input wire logic PIX_VALID_I,
   input wire logic [LVTG_PIX_W-1:0] PIX_DATA_I,
   output logic PIX_READY_O,
   output logic PANEL_PWR_O,
   output logic BACKLIGHT_O,
   output logic LINK_OE_O,
   output logic PIXEL_VALID_STROBE_O,
   output logic LINE_SYNC_O,
   output logic FRAME_SYNC_O,
   output logic SCAN_FLIP_O,
   output logic [LVTG_PIX_W-1:0] RGB_O,
   output logic UNDERRUN_O
);
   import lvtg_pkg::*;
   initial begin
      if (H_TOTAL < LVTG_H_TOTAL_MIN || H_TOTAL > LVTG_H_TOTAL_MAX)
         $error("line total out of range");
      if (V_TOTAL < LVTG_V_TOTAL_MIN || V_TOTAL > LVTG_V_TOTAL_MAX)
         $error("frame total out of range");
      if (FALL_CYC < 1 || SEQ_CYC < 1) $error("bad timing count");
   end
   localparam logic [LVTG_CNT_W-1:0] HT = LVTG_CNT_W'(H_TOTAL - 1);
   localparam logic [LVTG_CNT_W-1:0] VT = LVTG_CNT_W'(V_TOTAL - 1);
   localparam logic [LVTG_CNT_W-1:0] HA = LVTG_CNT_W'(LVTG_H_ACTIVE);
   localparam logic [LVTG_CNT_W-1:0] VA = LVTG_CNT_W'(LVTG_V_ACTIVE);
   localparam logic [31:0] FALL_N = 32'(FALL_CYC - 1);
   localparam logic [31:0] SEQ_N = 32'(SEQ_CYC - 1);

   // ---------------- system domain: power sequencer ----------------
   lvtg_pwr_t st_r;
   logic [31:0] tmr_r;
   logic pwr_r, bl_r, run_r, rdy_r, en_s1_r, en_s2_r;
   logic run_ack_s1_r, run_ack_s2_r, fifo_ready, und_s1_r, und_s2_r, und_r;
   logic link_run_r, und_lvl_r;
   wire tmr_done = (tmr_r == '0);
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         en_s1_r <= 1'b0;
         en_s2_r <= 1'b0;
         run_ack_s1_r <= 1'b0;
         run_ack_s2_r <= 1'b0;
         und_s1_r <= 1'b0;
         und_s2_r <= 1'b0;
      end else begin
         en_s1_r <= ENABLE_I;
         en_s2_r <= en_s1_r;
         run_ack_s1_r <= link_run_r;
         run_ack_s2_r <= run_ack_s1_r;
         und_s1_r <= und_lvl_r;
         und_s2_r <= und_s1_r;
      end
   end
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         st_r <= LVTG_OFF;
         tmr_r <= '0;
         pwr_r <= 1'b0;
         bl_r <= 1'b0;
         run_r <= 1'b0;
      end else begin
         if (!tmr_done) tmr_r <= tmr_r - 1'b1;
         unique case (st_r)
            LVTG_OFF: begin
               if (en_s2_r && tmr_done) begin
                  pwr_r <= 1'b1;
                  run_r <= 1'b1;
                  st_r <= LVTG_VIDEO_UP;
                  tmr_r <= SEQ_N;
               end
            end
            LVTG_VIDEO_UP: begin
               // light only once the link confirms video is running
               if (!en_s2_r) begin
                  run_r <= 1'b0;
                  st_r <= LVTG_LIGHT_DN;
                  tmr_r <= SEQ_N;
               end else if (run_ack_s2_r && tmr_done) begin
                  bl_r <= 1'b1;
                  st_r <= LVTG_LIGHT;
               end
            end
            LVTG_LIGHT: begin
               if (!en_s2_r) begin
                  bl_r <= 1'b0;
                  st_r <= LVTG_LIGHT_DN;
                  tmr_r <= SEQ_N;
               end
            end
            LVTG_LIGHT_DN: begin
               if (tmr_done) begin
                  run_r <= 1'b0;
                  if (!run_ack_s2_r) begin
                     pwr_r <= 1'b0;
                     st_r <= LVTG_FALL;
                     tmr_r <= FALL_N;
                  end
               end
            end
            LVTG_FALL: begin
               if (tmr_done) st_r <= LVTG_OFF;
            end
            default: begin
               st_r <= LVTG_OFF;
            end
         endcase
      end
   end
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rdy_r <= 1'b0;
         und_r <= 1'b0;
      end else begin
         rdy_r <= fifo_ready && run_r;
         und_r <= und_s2_r;
      end
   end
   assign PANEL_PWR_O = pwr_r;
   assign BACKLIGHT_O = bl_r;
   assign PIX_READY_O = rdy_r;
   assign UNDERRUN_O = und_r;

   // ---------------- link domain ----------------
   // link clock taken as given; any spreading is the source's job
   logic prst_s1_r, prst_b_r;
   always_ff @(posedge PIX_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         prst_s1_r <= 1'b0;
         prst_b_r <= 1'b0;
      end else begin
         prst_s1_r <= 1'b1;
         prst_b_r <= prst_s1_r;
      end
   end
   lvtg_fifo_if #(.W(LVTG_PIX_W)) fq ();
   lvtg_fifo #(.W(LVTG_PIX_W), .DEPTH(DEPTH)) u_fifo (
      .wclk_i(SYS_CLK_I),
      .wrst_b_i(RST_B_I),
      .w_valid_i(PIX_VALID_I && rdy_r),
      .w_ready_o(fifo_ready),
      .w_data_i(PIX_DATA_I),
      .rclk_i(PIX_CLK_I),
      .rrst_b_i(prst_b_r),
      .rd(fq)
   );
   logic run_s1_r, run_s2_r, pw_s1_r, pw_s2_r, fl_s1_r, fl_s2_r;
   logic m8_s1_r, m8_s2_r;
   logic [LVTG_CNT_W-1:0] h_r, v_r;
   logic de_r, oe_r, flip_r;
   logic [LVTG_PIX_W-1:0] rgb_r;
   always_ff @(posedge PIX_CLK_I or negedge prst_b_r) begin
      if (!prst_b_r) begin
         run_s1_r <= 1'b0;
         run_s2_r <= 1'b0;
         pw_s1_r <= 1'b0;
         pw_s2_r <= 1'b0;
         fl_s1_r <= 1'b0;
         fl_s2_r <= 1'b0;
         m8_s1_r <= 1'b0;
         m8_s2_r <= 1'b0;
      end else begin
         run_s1_r <= run_r;
         run_s2_r <= run_s1_r;
         pw_s1_r <= pwr_r;
         pw_s2_r <= pw_s1_r;
         fl_s1_r <= FLIP_I;
         fl_s2_r <= fl_s1_r;
         m8_s1_r <= MODE8_I;
         m8_s2_r <= m8_s1_r;
      end
   end
   wire line_end = (h_r == HT);
   wire frame_end = line_end && (v_r == VT);
   logic [LVTG_CNT_W-1:0] h_r_nxt, v_r_nxt;
   wire act_nxt = (h_r_nxt < HA) && (v_r_nxt < VA);
   always_comb begin
      h_r_nxt = line_end ? '0 : h_r + 1'b1;
      v_r_nxt = v_r;
      if (line_end) v_r_nxt = (v_r == VT) ? '0 : v_r + 1'b1;
      if (!link_run_r) begin
         h_r_nxt = '0;
         v_r_nxt = '0;
      end
   end
   always_ff @(posedge PIX_CLK_I or negedge prst_b_r) begin
      if (!prst_b_r) begin
         h_r <= '0;
         v_r <= '0;
         link_run_r <= 1'b0;
      end else begin
         // start and stop only on frame boundaries
         if (!link_run_r) link_run_r <= run_s2_r;
         else if (frame_end && !run_s2_r) link_run_r <= 1'b0;
         h_r <= (link_run_r && !(frame_end && !run_s2_r)) ? h_r_nxt : '0;
         v_r <= (link_run_r && !(frame_end && !run_s2_r)) ? v_r_nxt : '0;
      end
   end
   function automatic logic [LVTG_PIX_W-1:0] clamp6(input logic [23:0] p);
      return {2'b00, p[23:18], 2'b00, p[15:10], 2'b00, p[7:2]};
   endfunction
   // on start the first pixel of the frame is strobed, not skipped
   wire de_nxt = act_nxt &&
      (link_run_r ? !(frame_end && !run_s2_r) : run_s2_r);
   assign fq.ready = de_nxt;
   // strobe only in active area; black on underrun
   always_ff @(posedge PIX_CLK_I or negedge prst_b_r) begin
      if (!prst_b_r) begin
         de_r <= 1'b0;
         rgb_r <= '0;
         und_lvl_r <= 1'b0;
      end else begin
         de_r <= de_nxt;
         if (de_nxt && fq.valid)
            rgb_r <= m8_s2_r ? fq.data : clamp6(fq.data);
         else
            rgb_r <= {3{LVTG_BLACK}};
         if (de_nxt && !fq.valid) und_lvl_r <= ~und_lvl_r;
      end
   end
   // drive only while powered; flip strap
   always_ff @(posedge PIX_CLK_I or negedge prst_b_r) begin
      if (!prst_b_r) begin
         oe_r <= 1'b0;
         flip_r <= 1'b0;
      end else begin
         oe_r <= pw_s2_r;
         flip_r <= fl_s2_r && pw_s2_r;
      end
   end
   assign LINK_OE_O = oe_r;
   assign PIXEL_VALID_STROBE_O = de_r;
   assign RGB_O = rgb_r;
   assign SCAN_FLIP_O = flip_r;
   assign LINE_SYNC_O = 1'b0;
   assign FRAME_SYNC_O = 1'b0;

   sync_low_a: assert property (@(posedge SYS_CLK_I)
      !LINE_SYNC_O && !FRAME_SYNC_O)
      else $error("sync pin driven high");
   strobe_area_a: assert property (@(posedge PIX_CLK_I)
      disable iff (!prst_b_r) de_r |-> (h_r < HA) && (v_r < VA))
      else $error("strobe outside active area");
   line_wrap_a: assert property (@(posedge PIX_CLK_I)
      disable iff (!prst_b_r) link_run_r && line_end |=> h_r == '0)
      else $error("line did not wrap at its total");
   frame_bound_a: assert property (@(posedge PIX_CLK_I)
      disable iff (!prst_b_r) (h_r <= HT) && (v_r <= VT))
      else $error("counter beyond frame total");
   light_video_a: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_B_I) bl_r |-> run_ack_s2_r && pwr_r)
      else $error("backlight on without video");
   link_off_a: assert property (@(posedge PIX_CLK_I)
      disable iff (!prst_b_r) !pw_s2_r |=> !oe_r)
      else $error("link driven while unpowered");
   six_bit_a: assert property (@(posedge PIX_CLK_I)
      disable iff (!prst_b_r) de_nxt && fq.valid && !m8_s2_r
      |=> rgb_r[7:6] == 2'b00)
      else $error("6-bit code above full scale");
   line_done_c: cover property (@(posedge PIX_CLK_I)
      disable iff (!prst_b_r) link_run_r && line_end);
   light_on_c: cover property (@(posedge SYS_CLK_I)
      disable iff (!RST_B_I) $rose(bl_r));
   starve_c: cover property (@(posedge PIX_CLK_I)
      disable iff (!prst_b_r) de_nxt && !fq.valid);
endmodule

// ===== verilog/lvtg_pkg.sv
// constants and types for the lvds panel timing host
package lvtg_pkg;
   localparam int unsigned LVTG_H_ACTIVE = 1280;
   localparam int unsigned LVTG_H_TOTAL_MIN = 1360;
   localparam int unsigned LVTG_H_TOTAL_TYP = 1440;
   localparam int unsigned LVTG_H_TOTAL_MAX = 1600;
   localparam int unsigned LVTG_V_ACTIVE = 800;
   localparam int unsigned LVTG_V_TOTAL_MIN = 810;
   localparam int unsigned LVTG_V_TOTAL_TYP = 823;
   localparam int unsigned LVTG_V_TOTAL_MAX = 1000;
   localparam int unsigned LVTG_CNT_W = 11;
   localparam logic [7:0] LVTG_WHITE_8 = 8'hFF;
   localparam logic [7:0] LVTG_WHITE_6 = 8'h3F;
   localparam logic [7:0] LVTG_BLACK = 8'h00;
   localparam int unsigned LVTG_PIX_W = 24;
   localparam int unsigned LVTG_SYS_NS = 25;
   localparam int unsigned LVTG_FALL_MIN_MS = 10;
   localparam int unsigned LVTG_FALL_MAX_MS = 100;
   localparam int unsigned LVTG_SEQ_MS = 1;
   localparam longint unsigned LVTG_FALL_CYC =
      (longint'(LVTG_FALL_MIN_MS) * 1000000 + LVTG_SYS_NS - 1) / LVTG_SYS_NS;
   localparam longint unsigned LVTG_SEQ_CYC =
      (longint'(LVTG_SEQ_MS) * 1000000 + LVTG_SYS_NS - 1) / LVTG_SYS_NS;
   typedef enum logic [2:0] {
      LVTG_OFF, LVTG_VIDEO_UP, LVTG_LIGHT, LVTG_LIGHT_DN, LVTG_FALL
   } lvtg_pwr_t;
endpackage
